// ==== apb_cpu_model.sv ====
// APB master standing in for the CPU core's loads and stores.
// Assumes xfer is called just after a rising clk_i edge.
module apb_cpu_model (
    input  wire logic        clk_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    input  wire logic [31:0] prdata_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [31:0]      paddr_o,
    output logic [31:0]      pwdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Transfer
    // ****
    logic [31:0] rd_q;
    logic        err_q;
    int          wait_q;
    initial
    begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 32'h0;
        pwdata_o = 32'h0;
    end
    // A burst keeps psel high so the next setup follows the answer edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        input logic more);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        wait_q = 0;
        do
        begin
            @(posedge clk_i);
            wait_q++;
        end
        while (pready_i !== 1'b1 && wait_q < 400);
        rd_q = prdata_i;
        err_q = pslverr_i;
        penable_o <= 1'b0;
        if (!more)
        begin
            // Released address and data lines must not keep their last value
            psel_o <= 1'b0;
            paddr_o <= ~a;
            pwdata_o <= ~d;
            @(posedge clk_i);
        end
    endtask
endmodule // apb_cpu_model

// ==== data_memory_map_eeprom_access_tb_top.sv ====
// Bench for the data-space unit: map, pointers, EEPROM timing and modes.
// Assumes apb_cpu_model as bus master and the bound checker.
module data_memory_map_eeprom_access_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Bench
    // ****
    localparam int AT = 20;
    localparam int SP = 10;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        por_i = 1'b1;
    wire         psel, penable, pwrite, pready, pslverr;
    wire  [31:0] paddr, pwdata, prdata;
    int          n_mismatch = 0;
    int          n_tests = 0;
    integer      seed = 32'hE2F11B5A;
    logic [7:0]  mem [0:1279];
    logic [13:0] q [$];
    logic [13:0] corner [7] = '{14'h1F, 14'h20, 14'h5F, 14'h60, 14'hFF, 14'h100, 14'h4FF};
    always #10 clk_i = ~clk_i;
    data_space_unit #(.ATOMIC_CYCLES(AT), .SPLIT_CYCLES(SP)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr));
    apb_cpu_model cpu (
        .clk_i(clk_i), .pready_i(pready), .pslverr_i(pslverr),
        .prdata_i(prdata), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
    task automatic stop_test();
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] ad(input logic [1:0] w, input logic [13:0] i);
        return {14'h0, w, i, 2'h0};
    endfunction
    task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d,
                       input logic more = 1'b0);
        cpu.xfer(w, a, {16'h0, d}, more);
        if (cpu.wait_q >= 400)
        begin
            n_mismatch++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [13:0] a, input logic [15:0] d);
        bus(1'b1, ad(2'h0, a), d);
    endtask
    task automatic rd(input logic [13:0] a);
        bus(1'b0, ad(2'h0, a), 16'h0);
    endtask
    function automatic logic [7:0] ee_next(input logic [7:0] o, input logic [7:0] d,
                                           input logic [1:0] m);
        case (m)
            2'h0: return d;
            2'h1: return 8'hFF;
            2'h2: return o & d;
            default: return o;
        endcase
    endfunction
    task automatic ee_read(input logic [8:0] a, input logic [7:0] e);
        wr(14'h41, {8'h0, a[7:0]});
        wr(14'h42, {15'h0, a[8]});
        wr(14'h3F, 16'h1);
        check(cpu.wait_q, 32'h5);
        rd(14'h40);
        check(cpu.rd_q, {24'h0, e});
    endtask
    task automatic ee_prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m,
                           input logic poll);
        int k;
        int cy;
        cy = m == 2'h0 ? AT : SP;
        wr(14'h41, {8'h0, a[7:0]});
        wr(14'h42, {15'h0, a[8]});
        wr(14'h40, {8'h0, d});
        bus(1'b1, ad(2'h0, 14'h3F), {10'h0, m, 4'h4}, 1'b1);
        bus(1'b1, ad(2'h0, 14'h3F), {10'h0, m, 4'h2});
        check(cpu.wait_q, m == 2'h3 ? 32'h1 : 32'h3);
        if (poll)
        begin
            k = 0;
            do
            begin
                bus(1'b0, ad(2'h0, 14'h3F), 16'h0, 1'b1);
                k++;
            end
            while (cpu.rd_q[1] === 1'b1 && k < 200);
            rd(14'h3F);
            check(32'(m == 2'h3 ? k == 1 : k >= cy / 2 - 1 && k <= cy / 2 + 3), 32'h1);
            check(32'(cpu.rd_q[5:4]), 32'(m));
        end
    endtask
    initial
    begin
        logic [13:0] a;
        logic [7:0]  ed;
        logic [7:0]  ev;
        logic [8:0]  ea;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 48; i++)
        begin
            a = i < 7 ? corner[i] : 14'($unsigned($random(seed)) % 1280);
            // EEPROM registers have side effects, so they stay out of the plain map test
            if (a >= 14'h3F && a <= 14'h42)
                a = 14'h43;
            ed = 8'($random(seed));
            wr(a, {8'h0, ed});
            mem[a] = ed;
            q.push_back(a);
        end
        foreach (q[i])
        begin
            rd(q[i]);
            check(cpu.rd_q, {24'h0, mem[q[i]]});
        end
        wr(14'h500, 16'h5A);
        rd(14'h500);
        check(cpu.rd_q, 32'h0);
        wr(14'h65, 16'h3C);
        bus(1'b1, ad(2'h1, 14'h05), 16'hC3);
        rd(14'h25);
        check(cpu.rd_q, 32'hC3);
        bus(1'b0, ad(2'h1, 14'h45), 16'h0);
        check(cpu.rd_q, 32'hC3);
        wr(14'h1E, 16'h10);
        wr(14'h1F, 16'h01);
        bus(1'b1, ad(2'h2, 14'h2400), 16'hA1);
        rd(14'h110);
        check(cpu.rd_q, 32'hA1);
        rd(14'h1E);
        check(cpu.rd_q, 32'h11);
        wr(14'h1C, 16'h20);
        wr(14'h1D, 16'h01);
        bus(1'b1, ad(2'h2, 14'h1800), 16'hB2);
        rd(14'h11F);
        check(cpu.rd_q, 32'hB2);
        rd(14'h1C);
        check(cpu.rd_q, 32'h1F);
        wr(14'h150, 16'hD4);
        bus(1'b0, ad(2'h2, 14'h2C3F), 16'h0);
        check(cpu.rd_q, 32'hD4);
        wr(14'h1A, 16'h50);
        wr(14'h1B, 16'h01);
        bus(1'b0, ad(2'h2, 14'h0000), 16'h0);
        check(cpu.rd_q, 32'hD4);
        bus(1'b0, ad(2'h2, 14'h3000), 16'h0);
        check(32'(cpu.err_q), 32'h1);
        bus(1'b1, ad(2'h3, 14'h1FFF), 16'hA5C3);
        bus(1'b0, ad(2'h3, 14'h1FFF), 16'h0);
        check(cpu.rd_q, 32'hA5C3);
        for (int r = 0; r < 2; r++)
        begin
            ea = r == 0 ? 9'h1FF : 9'($random(seed));
            for (int m = 0; m < 4; m++)
            begin
                ed = 8'($random(seed));
                ee_prog(ea, ed, 2'(m), 1'b1);
                ev = ee_next(ev, ed, 2'(m));
                ee_read(ea, ev);
            end
        end
        wr(14'h40, {8'h0, ~ev});
        bus(1'b1, ad(2'h0, 14'h3F), 16'hC);
        repeat (4) @(posedge clk_i);
        rd(14'h3F);
        check(32'(cpu.rd_q[2:1]), 32'h0);
        check(32'(cpu.rd_q[3]), 32'h1);
        wr(14'h3F, 16'h2);
        check(cpu.wait_q, 32'h1);
        ee_read(ea, ev);
        ee_prog(9'h055, 8'h96, 2'h0, 1'b0);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (AT + 10) @(posedge clk_i);
        ee_read(9'h055, 8'h96);
        stop_test();
    end
endmodule // data_memory_map_eeprom_access_tb_top

// ==== data_space_defines.vh ====
// Constants for the data-space decoder and the data EEPROM.
// Included by the decoder and the EEPROM store; holds definitions only.
`ifndef DATA_SPACE_DEFINES_VH
`define DATA_SPACE_DEFINES_VH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS   20
`define EE_ATOMIC_NS    3400000
`define EE_SPLIT_NS     1800000
`define EE_RD_STALL     3'h4
`define EE_WR_STALL     3'h2
`define ARM_WINDOW      3'h4

// ****************************************
// Data-space map (largest variant: 1024-byte SRAM)
// ****************************************
`define IO_BASE         16'h0020
`define EXT_IO_BASE     16'h0060
`define SRAM_BASE       16'h0100
`define SRAM_SIZE       16'h0400
`define SRAM_WORDS      1024
`define IOEXT_WORDS     224
`define EE_WORDS        512
`define EE_AW           9
`define FLASH_WORDS     8192
`define PC_W            13
`define PTR_X_LO        5'h1A

// ****************************************
// EEPROM register indexes (byte address is four times the index)
// ****************************************
`define EECR_IDX        16'h003F
`define EEDR_IDX        16'h0040
`define EEARL_IDX       16'h0041
`define EEARH_IDX       16'h0042
`define EECR_READ       0
`define EECR_STROBE     1
`define EECR_ARM        2
`define EECR_RDY_IE     3
`define EECR_MODE_LO    4
`define EECR_RESET      8'h00

// ****************************************
// APB windows, indirect modes, EEPROM modes
// ****************************************
`define WIN_DIRECT      2'h0
`define WIN_IOPORT      2'h1
`define WIN_INDIRECT    2'h2
`define WIN_PROG        2'h3
`define IND_PLAIN       2'h0
`define IND_POSTINC     2'h1
`define IND_PREDEC      2'h2
`define IND_DISP        2'h3
`define PTR_BAD         2'h3
`define EE_MODE_ATOMIC  2'h0
`define EE_MODE_ERASE   2'h1
`define EE_MODE_WRITE   2'h2
`define EE_MODE_RSVD    2'h3
`define EE_ERASED       8'hFF

`endif

// ==== data_space_unit.v ====
// Data-space decoder: register file, I/O, extended I/O, SRAM, program
// memory window and the data EEPROM registers, reached over APB.
// Assumes an APB master on clk_i and a separate power-on reset por_i.
//
// The implementer's own choices: the address map and the APB register port.
`include "data_space_defines.vh"

module data_space_unit #(
    parameter [31:0] ATOMIC_CYCLES = (`EE_ATOMIC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter [31:0] SPLIT_CYCLES  = (`EE_SPLIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        por_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [31:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o
);

    localparam [1:0] S_IDLE  = 2'b00;
    localparam [1:0] S_STALL = 2'b01;
    localparam [1:0] S_READY = 2'b10;

    // ****************************************
    // Storage
    // ****************************************
    reg [7:0]  regs_m  [0:31];
    reg [7:0]  ioext_m [0:`IOEXT_WORDS-1];
    reg [7:0]  sram_m  [0:`SRAM_WORDS-1];
    reg [15:0] flash_m [0:`FLASH_WORDS-1];

    reg [1:0]         state_q;
    reg [2:0]         stall_q;
    reg [1:0]         win_q;
    reg [13:0]        idx_q;
    reg               wr_q;
    reg [15:0]        wd_q;
    reg               rd_go_q;
    reg               wr_go_q;
    reg [31:0]        prdata_q;
    reg               pready_q;
    reg               pslverr_q;
    reg               arm_q;
    reg [2:0]         arm_cnt_q;
    reg               rdy_ie_q;
    reg [7:0]         eedr_q;
    reg [`EE_AW-1:0]  eear_q;
    reg [15:0]        rd_word;

    wire [1:0] ee_mode;
    wire       ee_busy;
    wire [7:0] ee_rdata;

    // ****************************************
    // Request view: live bus in setup, latched copy afterwards
    // ****************************************
    wire        idle    = (state_q == S_IDLE);
    wire        setup   = idle && psel_i && !penable_i;
    wire        commit  = (state_q == S_READY) && psel_i && penable_i;
    wire [1:0]  cur_win = idle ? paddr_i[17:16] : win_q;
    wire [13:0] cur_idx = idle ? paddr_i[15:2] : idx_q;
    wire        cur_wr  = idle ? pwrite_i : wr_q;
    wire [15:0] cur_wd  = idle ? pwdata_i[15:0] : wd_q;

    // Pointer pairs: X at 26/27, Y at 28/29, Z at 30/31, low byte first
    wire [4:0]  ptr_lo  = `PTR_X_LO + {2'b00, cur_idx[13:12], 1'b0};
    wire [4:0]  ptr_hi  = ptr_lo | 5'h01;
    wire [15:0] ptr     = {regs_m[ptr_hi], regs_m[ptr_lo]};
    wire [1:0]  ind_mode = cur_idx[11:10];
    wire        is_ind  = (cur_win == `WIN_INDIRECT);
    wire        ptr_bad = is_ind && (cur_idx[13:12] == `PTR_BAD);
    wire        is_prog = (cur_win == `WIN_PROG);

    reg [15:0] ea;

    always @*
    begin
        case (cur_win)
            `WIN_IOPORT:
                ea = `IO_BASE + {10'h000, cur_idx[5:0]};
            `WIN_INDIRECT:
            begin
                case (ind_mode)
                    `IND_PREDEC:
                        ea = ptr - 16'h0001;
                    `IND_DISP:
                        if (cur_idx[13:12] != 2'b00)
                            ea = ptr + {10'h000, cur_idx[5:0]};
                        else
                            ea = ptr;
                    default:
                        ea = ptr;
                endcase
            end
            default:
                ea = {3'b000, cur_idx[12:0]};
        endcase
    end

    wire [15:0] ptr_next = (ind_mode == `IND_PREDEC) ? ea : ptr + 16'h0001;
    wire        ptr_upd  = is_ind && !ptr_bad &&
                           (ind_mode == `IND_POSTINC || ind_mode == `IND_PREDEC);

    // ****************************************
    // Region decode
    // ****************************************
    wire [15:0] io_rel   = ea - `IO_BASE;
    wire [15:0] sram_rel = ea - `SRAM_BASE;
    wire        in_reg   = (ea < `IO_BASE);
    wire        in_ioext = !in_reg && (ea < `SRAM_BASE);
    wire        in_sram  = (ea >= `SRAM_BASE) && (sram_rel < `SRAM_SIZE);
    wire        mapped   = !is_prog && !ptr_bad;

    wire is_eecr  = mapped && (ea == `EECR_IDX);
    wire is_eedr  = mapped && (ea == `EEDR_IDX);
    wire is_earl  = mapped && (ea == `EEARL_IDX);
    wire is_earh  = mapped && (ea == `EEARH_IDX);
    wire is_ee    = is_eecr || is_eedr || is_earl || is_earh;

    wire [7:0] eecr_val = {2'b00, ee_mode, rdy_ie_q, arm_q, ee_busy, 1'b0};

    // A read trigger wins over a strobe written in the same byte
    wire ee_wr   = is_eecr && cur_wr;
    wire rd_go   = ee_wr && cur_wd[`EECR_READ] && !ee_busy;
    wire wr_go   = ee_wr && cur_wd[`EECR_STROBE] && !cur_wd[`EECR_READ] &&
                   arm_q && !ee_busy && (ee_mode != `EE_MODE_RSVD);
    wire [2:0] stall = rd_go ? `EE_RD_STALL : (wr_go ? `EE_WR_STALL : 3'h0);

    // ****************************************
    // Read mux
    // ****************************************
    always @*
    begin
        rd_word = 16'h0000;
        if (is_prog)
            rd_word = flash_m[cur_idx[`PC_W-1:0]];
        else if (ptr_bad)
            rd_word = 16'h0000;
        else if (in_reg)
            rd_word = {8'h00, regs_m[ea[4:0]]};
        else if (is_eecr)
            rd_word = {8'h00, eecr_val};
        else if (is_eedr)
            rd_word = {8'h00, eedr_q};
        else if (is_earl)
            rd_word = {8'h00, eear_q[7:0]};
        else if (is_earh)
            rd_word = {15'h0000, eear_q[8]};
        else if (in_ioext)
            rd_word = {8'h00, ioext_m[io_rel[7:0]]};
        else if (in_sram)
            rd_word = {8'h00, sram_m[sram_rel[9:0]]};
        else
            rd_word = 16'h0000;
    end

    // ****************************************
    // APB slave and EEPROM control
    // ****************************************
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q   <= S_IDLE;
            stall_q   <= 3'h0;
            win_q     <= `WIN_DIRECT;
            idx_q     <= 14'h0000;
            wr_q      <= 1'b0;
            wd_q      <= 16'h0000;
            rd_go_q   <= 1'b0;
            wr_go_q   <= 1'b0;
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            arm_q     <= 1'b0;
            arm_cnt_q <= 3'h0;
            rdy_ie_q  <= 1'b0;
            eedr_q    <= 8'h00;
            eear_q    <= {`EE_AW{1'b0}};
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    if (setup)
                    begin
                        win_q   <= paddr_i[17:16];
                        idx_q   <= paddr_i[15:2];
                        wr_q    <= pwrite_i;
                        wd_q    <= pwdata_i[15:0];
                        rd_go_q <= rd_go;
                        wr_go_q <= wr_go;
                        stall_q <= stall;
                        if (stall == 3'h0)
                        begin
                            // Plain accesses finish in setup plus one access cycle
                            pready_q  <= 1'b1;
                            prdata_q  <= {16'h0000, rd_word};
                            pslverr_q <= ptr_bad;
                            state_q   <= S_READY;
                        end
                        else
                            state_q <= S_STALL;
                    end
                end
                S_STALL:
                begin
                    stall_q <= stall_q - 3'h1;
                    if (stall_q == 3'h1)
                    begin
                        pready_q  <= 1'b1;
                        prdata_q  <= {16'h0000, rd_word};
                        pslverr_q <= 1'b0;
                        state_q   <= S_READY;
                    end
                end
                S_READY:
                begin
                    if (commit)
                    begin
                        pready_q  <= 1'b0;
                        pslverr_q <= 1'b0;
                        state_q   <= S_IDLE;
                        if (rd_go_q)
                            eedr_q <= ee_rdata;
                        if (wr_q && is_eedr)
                            eedr_q <= wd_q[7:0];
                        if (wr_q && is_earl)
                            eear_q[7:0] <= wd_q[7:0];
                        if (wr_q && is_earh)
                            eear_q[8] <= wd_q[0];
                        if (wr_q && is_eecr)
                            rdy_ie_q <= wd_q[`EECR_RDY_IE];
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase

            // Arm window: a fresh arm restarts the count
            if (commit && wr_q && is_eecr && wd_q[`EECR_ARM])
            begin
                arm_q     <= 1'b1;
                arm_cnt_q <= `ARM_WINDOW;
            end
            else if (commit && wr_go_q)
            begin
                arm_q     <= 1'b0;
                arm_cnt_q <= 3'h0;
            end
            else if (arm_q)
            begin
                arm_cnt_q <= arm_cnt_q - 3'h1;
                if (arm_cnt_q == 3'h1)
                    arm_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Array writes and pointer write-back
    // ****************************************
    // Pointer update comes first so a store into the pointer itself wins
    always @(posedge clk_i)
    begin
        if (commit && ptr_upd)
        begin
            regs_m[ptr_lo] <= ptr_next[7:0];
            regs_m[ptr_hi] <= ptr_next[15:8];
        end
        if (commit && wr_q)
        begin
            if (is_prog)
                flash_m[idx_q[`PC_W-1:0]] <= wd_q;
            else if (!ptr_bad && in_reg)
                regs_m[ea[4:0]] <= wd_q[7:0];
            else if (!ptr_bad && in_ioext && !is_ee)
                ioext_m[io_rel[7:0]] <= wd_q[7:0];
            else if (!ptr_bad && in_sram)
                sram_m[sram_rel[9:0]] <= wd_q[7:0];
        end
    end

    // ****************************************
    // EEPROM store
    // ****************************************
    // Start fires on the committing edge, after the two-cycle stall
    eeprom_store #(
        .ATOMIC_CYCLES (ATOMIC_CYCLES),
        .SPLIT_CYCLES  (SPLIT_CYCLES)
    ) u_ee (
        .clk_i     (clk_i),
        .por_i     (por_i),
        .rst_i     (rst_i),
        .start_i   (commit && wr_go_q),
        .mode_wr_i (commit && wr_q && is_eecr),
        .mode_i    (wd_q[`EECR_MODE_LO+1:`EECR_MODE_LO]),
        .addr_i    (eear_q),
        .data_i    (eedr_q),
        .mode_o    (ee_mode),
        .busy_o    (ee_busy),
        .rdata_o   (ee_rdata)
    );

    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;

endmodule // data_space_unit

// ==== data_space_unit_props.sv ====
// Checker of the APB answers of the data-space unit.
// Sees only the top ports; stall claims assume an idle EEPROM.
module data_space_unit_props #(
    parameter [31:0] ATOMIC_CYCLES = 32'h14,
    parameter [31:0] SPLIT_CYCLES  = 32'h0A
)(
    input wire        clk_i,
    input wire        rst_i,
    input wire        por_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [31:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o
);
    // ****
    // Properties
    // ****
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i || por_i);
    wire       setup = psel_i && !penable_i;
    wire [1:0] win   = paddr_i[17:16];
    wire       ctl   = (win == 2'h0 && paddr_i[15:2] == 14'h003F) ||
                       (win == 2'h1 && paddr_i[7:2] == 6'h1F);
    sequence arm_done;
        pready_o && pwrite_i && ctl && pwdata_i[2:0] == 3'h4;
    endsequence
    sequence strobe_go(m3);
        setup && pwrite_i && ctl && pwdata_i[1:0] == 2'h2 && (pwdata_i[5:4] == 2'h3) == m3;
    endsequence
    a_plain_two_cycle: assert property (
        setup && !(pwrite_i && (ctl || win == 2'h2)) |=> pready_o)
        else $error("plain access answer late");
    a_read_stall: assert property (
        setup && pwrite_i && ctl && pwdata_i[0] |=> !pready_o [*4] ##1 pready_o)
        else $error("read stall not four cycles");
    a_write_stall: assert property (
        arm_done ##1 strobe_go(1'b0) |=> !pready_o [*2] ##1 pready_o)
        else $error("write stall not two cycles");
    a_rsvd_no_stall: assert property (arm_done ##1 strobe_go(1'b1) |=> pready_o)
        else $error("reserved mode stalled");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("pready outside access");
    a_err_pointer: assert property (
        pready_o |-> pslverr_o == (win == 2'h2 && paddr_i[15:14] == 2'h3))
        else $error("pslverr wrong");
    a_rdata_hold: assert property (!pready_o |-> $stable(prdata_o))
        else $error("prdata changed without answer");
    a_upper_zero: assert property (pready_o && win != 2'h3 |-> prdata_o[31:8] == 24'h0)
        else $error("upper read bits set");
    // Direct indexes wrap above bit 12, so only the unaliased range is claimed
    a_above_sram: assert property (
        pready_o && !pwrite_i && win == 2'h0 && !paddr_i[15] &&
        paddr_i[15:2] >= 14'h0500 |-> prdata_o == 32'h0)
        else $error("read above sram not zero");
endmodule // data_space_unit_props

bind data_space_unit data_space_unit_props #(
    .ATOMIC_CYCLES(ATOMIC_CYCLES),
    .SPLIT_CYCLES(SPLIT_CYCLES)
) props (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o));

// ==== eeprom_store.v ====
// Byte-wide data EEPROM array with its self-timed programming engine.
// Assumes start_i is a one-cycle pulse from the decoder; por_i is power-on only.
`include "data_space_defines.vh"

module eeprom_store #(
    parameter [31:0] ATOMIC_CYCLES = 32'd170000,
    parameter [31:0] SPLIT_CYCLES  = 32'd90000
)(
    input  wire             clk_i,
    input  wire             por_i,
    input  wire             rst_i,
    input  wire             start_i,
    input  wire             mode_wr_i,
    input  wire [1:0]       mode_i,
    input  wire [`EE_AW-1:0] addr_i,
    input  wire [7:0]       data_i,
    output wire [1:0]       mode_o,
    output wire             busy_o,
    output wire [7:0]       rdata_o
);

    reg [7:0]        mem_m [0:`EE_WORDS-1];
    reg [1:0]        mode_q;
    reg [1:0]        op_q;
    reg              busy_q;
    reg [31:0]       timer_q;
    reg [`EE_AW-1:0] addr_q;
    reg [7:0]        data_q;

    wire done = busy_q && (timer_q == 32'd1);

    // ****************************************
    // Programming engine
    // ****************************************
    // Only power-on clears the timer and operation; a core reset just returns an idle mode to atomic, so it cannot cut a cell write
    always @(posedge clk_i or posedge por_i)
    begin
        if (por_i)
        begin
            mode_q  <= `EE_MODE_ATOMIC;
            op_q    <= `EE_MODE_ATOMIC;
            busy_q  <= 1'b0;
            timer_q <= 32'd0;
            addr_q  <= {`EE_AW{1'b0}};
            data_q  <= 8'h00;
        end
        else
        begin
            if (busy_q)
            begin
                timer_q <= timer_q - 32'd1;
                if (done)
                    busy_q <= 1'b0;
            end
            else if (start_i && mode_q != `EE_MODE_RSVD)
            begin
                busy_q  <= 1'b1;
                op_q    <= mode_q;
                addr_q  <= addr_i;
                data_q  <= data_i;
                timer_q <= (mode_q == `EE_MODE_ATOMIC) ? ATOMIC_CYCLES : SPLIT_CYCLES;
            end
            if (!busy_q && !start_i && mode_wr_i)
                mode_q <= mode_i;
            else if (!busy_q && rst_i)
                mode_q <= `EE_MODE_ATOMIC;
        end
    end

    // ****************************************
    // Cell update at the end of the timed operation
    // ****************************************
    always @(posedge clk_i)
    begin
        if (done)
        begin
            case (op_q)
                `EE_MODE_ATOMIC: mem_m[addr_q] <= data_q;
                `EE_MODE_ERASE:  mem_m[addr_q] <= `EE_ERASED;
                `EE_MODE_WRITE:  mem_m[addr_q] <= mem_m[addr_q] & data_q;
                default:         mem_m[addr_q] <= mem_m[addr_q];
            endcase
        end
    end

    assign rdata_o = mem_m[addr_i];
    assign mode_o  = mode_q;
    assign busy_o  = busy_q;

endmodule // eeprom_store
